// ==== prsi_top.sv ====
////////////////////////////////////////////////////////////////////////////////
// Purpose: reset, settle, strap capture and bus reset start for a 3-port phy
// Assumes: apb slave, zero wait states; straps synchronous to pclk
// Notes:   the link clock is synthesised from pclk, so it carries jitter
////////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module prsi_top
  import prsi_pkg::*;
#(
  parameter int SETTLE_CYCLES    = SETTLE_CYC,
  parameter int BUS_RESET_CYCLES = BUS_RESET_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 contender_strap,
  input  wire logic                 link_active_strap,
  input  wire logic                 all_ports_off_strap,
  input  wire logic [PWRC_W-1:0]    power_class_strap,
  input  wire logic                 iso_sel,
  output logic                      sclk_out,
  output logic [1:0]                link_ctl_out,
  output logic [7:0]                link_data_out,
  output logic                      link_oe_n,
  output logic                      operational,
  output logic                      bus_reset_active,
  output logic                      isolation_en,
  output logic                      contender,
  output logic                      link_active,
  output logic [PWRC_W-1:0]         power_class,
  output logic [NUM_PORTS-1:0]      port_disabled
);

  localparam logic [TIMER_W-1:0] SETTLE_LD = TIMER_W'(SETTLE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] BUSRST_LD = TIMER_W'(BUS_RESET_CYCLES - 1);

  prsi_state_e            state_r;
  prsi_state_e            state_nxt;
  logic                   tmr_done;
  logic                   contender_r;
  logic                   link_act_r;
  logic                   iso_r;
  logic [PWRC_W-1:0]      pwrc_r;
  logic [NUM_PORTS-1:0]   pdis_r;
  logic [PHASE_W-1:0]     phase_r;
  logic                   oe_n_r;
  logic [31:0]            prdata_r;
  logic [TIMER_W-1:0]     cyc_r;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire hit_ctrl   = (paddr == CTRL_OFS);
  wire hit_stat   = (paddr == STAT_OFS);
  wire rd_setup   = psel && !penable && !pwrite;
  wire wr_access  = psel && penable && pwrite;
  wire ctrl_wr    = wr_access && hit_ctrl;

  wire [31:0] ctrl_val = {27'h0, pdis_r, link_act_r, 1'b0};
  wire [31:0] stat_val = {21'h0, pdis_r, pwrc_r, link_act_r, contender_r, iso_r,
                          bus_reset_active, operational};
  wire [31:0] rd_val   = hit_ctrl ? ctrl_val : (hit_stat ? stat_val : 32'h0);

  // zero wait states keep the slave simple; data is latched in the setup phase
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || hit_stat);
  assign prdata  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  wire settle_done  = (state_r == ST_SETTLE) && tmr_done;
  wire soft_busrst  = ctrl_wr && pwdata[CTRL_BUSRST_BIT] && (state_r == ST_RUN);
  wire tmr_load     = (state_r == ST_START) || settle_done || soft_busrst;
  wire [TIMER_W-1:0] tmr_val = (state_r == ST_START) ? SETTLE_LD : BUSRST_LD;
  wire capture      = settle_done;
  wire sw_write_ok  = ctrl_wr && operational;
  wire iso_nxt      = capture ? iso_sel : iso_r;
  wire oper_nxt     = (state_nxt == ST_BUSRST) || (state_nxt == ST_RUN);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_START:  state_nxt = ST_SETTLE;
      ST_SETTLE: if (tmr_done) state_nxt = ST_BUSRST;
      ST_BUSRST: if (tmr_done) state_nxt = ST_RUN;
      ST_RUN:    if (soft_busrst) state_nxt = ST_BUSRST;
    endcase
  end

  prsi_timer #(
    .W        (TIMER_W)
  ) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // everything stops and returns to power-on values under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_START;
      oe_n_r  <= 1'b1;
      phase_r <= '0;
    end else begin
      state_r <= state_nxt;
      oe_n_r  <= !(oper_nxt && !iso_nxt);
      phase_r <= operational ? phase_r + SCLK_INC : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture, taken once at the end of settling

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contender_r <= CONT_RST;
      iso_r       <= ISO_RST;
      pwrc_r      <= PWRC_RST;
    end else if (capture) begin
      contender_r <= contender_strap;
      iso_r       <= iso_sel;
      pwrc_r      <= power_class_strap;
    end
  end

  // software may change these later; the strap only presets them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_act_r <= LINK_ACT_RST;
      pdis_r     <= PDIS_RST;
    end else if (capture) begin
      link_act_r <= link_active_strap;
      pdis_r     <= {NUM_PORTS{all_ports_off_strap}};
    end else if (sw_write_ok) begin
      link_act_r <= pwdata[CTRL_LINK_ACT_BIT];
      pdis_r     <= pwdata[CTRL_PDIS_LSB +: NUM_PORTS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (rd_setup) begin
      prdata_r <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign operational      = (state_r == ST_BUSRST) || (state_r == ST_RUN);
  assign bus_reset_active = (state_r == ST_BUSRST);
  assign sclk_out         = phase_r[PHASE_W-1];
  assign link_oe_n        = oe_n_r;
  // only the idle level is produced here; transfers belong to the link interface
  assign link_ctl_out     = 2'h0;
  assign link_data_out    = 8'h00;
  assign isolation_en     = iso_r;
  assign contender        = contender_r;
  assign link_active      = link_act_r;
  assign power_class      = pwrc_r;
  assign port_disabled    = pdis_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= '0;
    end else if (state_nxt != state_r) begin
      cyc_r <= '0;
    end else begin
      cyc_r <= cyc_r + 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence settle_end_s;
    (state_r == ST_SETTLE) && tmr_done;
  endsequence

  property settle_then_busrst_p;
    settle_end_s |=> bus_reset_active && operational;
  endproperty

  settle_quiet_a: assert property ((state_r == ST_SETTLE) |-> !operational && !sclk_out && link_oe_n)
    else $error("activity seen before settling ended");
  busrst_start_a: assert property (settle_then_busrst_p)
    else $error("bus reset did not follow settling");
  busrst_len_a: assert property ($fell(bus_reset_active) |-> $past(cyc_r) == BUS_RESET_CYCLES - 1)
    else $error("bus reset length wrong");
  contender_cap_a: assert property ($rose(operational) |-> contender == $past(contender_strap))
    else $error("contender not taken from strap");
  link_act_cap_a: assert property ($rose(operational) |-> link_active == $past(link_active_strap))
    else $error("link active not taken from strap");
  pdis_cap_a: assert property ($rose(operational) |-> port_disabled == {NUM_PORTS{$past(all_ports_off_strap)}})
    else $error("port disable not taken from strap");
  iso_cap_a: assert property ($rose(operational) |-> isolation_en == $past(iso_sel))
    else $error("isolation select not taken");
  sclk_run_a: assert property (operational && $past(operational) |-> ##[0:2] (sclk_out != $past(sclk_out)))
    else $error("link clock stalled");
  settle_len_a: assert property ($rose(operational) |-> $past(cyc_r) == SETTLE_CYCLES - 1)
    else $error("settle time wrong");
  link_drive_a: assert property (link_oe_n == !(operational && !isolation_en))
    else $error("link output enable wrong");
  strap_hold_a: assert property (operational && $past(operational) |-> $stable(contender) && $stable(power_class))
    else $error("strap value changed after capture");

endmodule

// ==== prsi_pkg.sv ====
////////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types for the phy reset and strap init block
// Assumes: pclk at 125 MHz
// Notes:   timing counts are derived from the times below
////////////////////////////////////////////////////////////////////////////////
package prsi_pkg;

  // clock and timing
  localparam int CLK_MHZ       = 125;
  localparam int CLK_KHZ       = CLK_MHZ * 1000;
  localparam int SETTLE_US     = 500;
  localparam int BUS_RESET_US  = 166;
  localparam int SETTLE_CYC    = SETTLE_US * CLK_MHZ;
  localparam int BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ;
  localparam int TIMER_W       = 17;

  // link clock synthesis by phase accumulator
  localparam int              SCLK_KHZ = 49152;
  localparam int              PHASE_W  = 24;
  localparam logic [PHASE_W-1:0] SCLK_INC =
    PHASE_W'((longint'(SCLK_KHZ) << PHASE_W) / longint'(CLK_KHZ));

  // port counts and widths
  localparam int NUM_PORTS = 3;
  localparam int PWRC_W    = 3;
  localparam int ADDR_W    = 12;

  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;

  // control fields
  localparam int CTRL_BUSRST_BIT   = 0;
  localparam int CTRL_LINK_ACT_BIT = 1;
  localparam int CTRL_PDIS_LSB     = 2;

  // status fields
  localparam int STAT_OPER_BIT   = 0;
  localparam int STAT_BUSRST_BIT = 1;
  localparam int STAT_ISO_BIT    = 2;
  localparam int STAT_CONT_BIT   = 3;
  localparam int STAT_LINK_ACT_BIT = 4;
  localparam int STAT_PWRC_LSB     = 5;
  localparam int STAT_PDIS_LSB   = 8;

  // reset values
  localparam logic                 LINK_ACT_RST = 1'h0;
  localparam logic                 CONT_RST     = 1'h0;
  localparam logic                 ISO_RST      = 1'h0;
  localparam logic [NUM_PORTS-1:0] PDIS_RST     = 3'h0;
  localparam logic [PWRC_W-1:0]    PWRC_RST     = 3'h0;

  typedef enum logic [1:0] {
    ST_START,
    ST_SETTLE,
    ST_BUSRST,
    ST_RUN
  } prsi_state_e;

endpackage

// ==== prsi_timer.sv ====
////////////////////////////////////////////////////////////////////////////////
// Purpose: loadable down counter for the settle and bus reset phases
// Assumes: load wins over counting
// Notes:   done is high while the count stands at zero
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module prsi_timer #(
  parameter int W = 17
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_val;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign done = (count_r == '0);

endmodule

// ==== prsi_board.sv ====
// Purpose: board strap wiring and link device clock watcher
// Assumes: straps are static levels set by the bench
// Notes:   the link device only counts clock edges
`timescale 1ns/1ps
module prsi_board (
  input  wire logic       sclk_out,
  input  wire logic [7:0] cfg,
  output logic            contender_strap,
  output logic            link_active_strap,
  output logic            all_ports_off_strap,
  output logic            iso_sel,
  output logic [2:0]      power_class_strap,
  output int              sclk_edges
);
  // straps are tied levels, not toggled, so any change is a rewiring
  assign contender_strap     = cfg[0];
  assign link_active_strap   = cfg[1];
  assign all_ports_off_strap = cfg[2];
  assign iso_sel             = cfg[3];
  assign power_class_strap   = cfg[6:4];
  initial sclk_edges = 0;
  always @(posedge sclk_out) begin
    sclk_edges <= sclk_edges + 1;
  end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the reset and strap init block
// Assumes: short settle and bus reset counts
// Notes:   straps are rewired after capture to probe holding
`timescale 1ns/1ps
module testbench
  import prsi_pkg::*;
;
  localparam int SET = 20;
  localparam int BR  = 10;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, seed;
  logic              c_s, l_s, p_s, iso_sel, sclk_out, link_oe_n, operational;
  logic              bus_reset_active, isolation_en, contender, link_active;
  logic [2:0]        pwrc_s, power_class, port_disabled;
  logic [1:0]        link_ctl_out;
  logic [7:0]        link_data_out, cfg, c;
  int                errors, tests_run, n, e0, ex;
  ////////////////////////////////////////////////////////////////////////////
  prsi_top #(.SETTLE_CYCLES(SET), .BUS_RESET_CYCLES(BR)) u_prsi_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contender_strap(c_s), .link_active_strap(l_s), .all_ports_off_strap(p_s),
    .power_class_strap(pwrc_s), .iso_sel(iso_sel), .sclk_out(sclk_out),
    .link_ctl_out(link_ctl_out), .link_data_out(link_data_out), .link_oe_n(link_oe_n),
    .operational(operational), .bus_reset_active(bus_reset_active),
    .isolation_en(isolation_en), .contender(contender), .link_active(link_active),
    .power_class(power_class), .port_disabled(port_disabled));
  prsi_board u_prsi_board (.sclk_out(sclk_out), .cfg(cfg), .contender_strap(c_s),
    .link_active_strap(l_s), .all_ports_off_strap(p_s), .iso_sel(iso_sel),
    .power_class_strap(pwrc_s), .sclk_edges(e0));
  ////////////////////////////////////////////////////////////////////////////
  // pclk stands in for the board reference clock
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task print_verdict;
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task tmo(input int k, input int lim);
    if (k >= lim) begin
      chk(1'h0, "wait ran out");
      print_verdict;
    end
  endtask
  // waits for pready, so up to 48 wait states are accepted before the wait runs out
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata; err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    tmo(k, 50);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h000; pwdata = 32'h0; cfg = 8'h00; seed = 32'hef37;
    errors = 0; tests_run = 0;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      c = {1'h0, seed[6:4], i[0], i[1] ^ seed[2], seed[1:0]};
      @(posedge pclk);
      presetn <= 1'h0; cfg <= c;
      repeat (3) @(posedge pclk);
      chk(operational === 1'h0 && link_oe_n === 1'h1 && sclk_out === 1'h0, "active in reset");
      presetn <= 1'h1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
        if (operational !== 1'h1) chk(link_oe_n === 1'h1, "drives early");
      end while (operational !== 1'h1 && n < 100);
      tmo(n, 100);
      chk(n >= SET && n <= SET + 3, "settle length");
      chk(bus_reset_active === 1'h1, "no bus reset");
      chk(link_oe_n === c[3] && link_data_out === 8'h00 && link_ctl_out === 2'h0, "link idle");
      cfg <= ~c;
      n = 0;
      while (bus_reset_active === 1'h1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      tmo(n, 100);
      chk(n >= BR - 1 && n <= BR + 1, "bus reset length");
      ex = (1 << STAT_OPER_BIT) | (c[3] << STAT_ISO_BIT) | (c[0] << STAT_CONT_BIT) | (c[1] << STAT_LINK_ACT_BIT)
         | (c[6:4] << STAT_PWRC_LSB) | ({3{c[2]}} << STAT_PDIS_LSB);
      chk(contender === c[0] && link_active === c[1], "strap bits");
      chk(port_disabled === {3{c[2]}} && isolation_en === c[3] && power_class === c[6:4], "straps");
      apb(1'h0, STAT_OFS, 32'h0);
      chk(rd === 32'(ex) && err === 1'h0, "status word");
      n = e0;
      repeat (1000) @(posedge pclk);
      chk(e0 - n >= 392 && e0 - n <= 394, "link clock rate");
      // software may override the preset bits once running; bit0 stays clear here
      seed = xs(seed);
      ex = (seed[1] << CTRL_LINK_ACT_BIT) | (seed[4:2] << CTRL_PDIS_LSB);
      apb(1'h1, CTRL_OFS, 32'(ex));
      apb(1'h0, CTRL_OFS, 32'h0);
      chk(rd === 32'(ex) && err === 1'h0 && link_active === seed[1], "control word");
      chk(port_disabled === seed[4:2] && bus_reset_active === 1'h0, "port override");
      apb(1'h1, CTRL_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      chk(bus_reset_active === 1'h1, "soft bus reset");
      apb(1'h0, 12'h008, 32'h0);
      chk(err === 1'h1 && rd === 32'h0, "unmapped read");
    end
    print_verdict;
  end
endmodule
